// [src/lcd_display_core.v]
// Notes on behaviour
// - 5x10: code bits 2:1 give glyph address 5:4
// - 5x10: glyph address bits 3:0 pick row
// - 5x10: eleventh row carries the cursor
// - 5x10: rows 12 to 16 never show dots, only the blink block in two-line mode
// - codes 00h-0Fh use user glyphs, aliased
// - pattern bit one lights the dot
// - internal timing sequences refresh memory fetches
// - host access never disturbs refresh data
// - columns 41-400 shifted out, 1-40 local
// - two-line mode ends expansion at 200
// - sixteen row and forty column outputs
// - unused rows get off waveform
// - cursor at address counter position
// - glyph address in counter still shows cursor
// - power-up init holds busy flag high
// - init clears text ram, counter zero
// - data bits 4:0 shown, 7:5 stored
// - busy during execution, only host memory writes blocked
`timescale 1ns/1ps
`include "lcd_core_map.vh"
module lcd_display_core #(
    parameter INIT_CYCLES = `LCD_INIT_CYCLES
) (
    // clock and reset
    input wire clock,
    input wire rst,
    // configuration
    input wire font_5x10,
    input wire two_line,
    // control loads from instruction decoder
    input wire ctrl_load,
    input wire display_on_in,
    input wire cursor_on_in,
    input wire blink_on_in,
    input wire exec_busy,
    // address counter
    input wire ac_load,
    input wire [6:0] ac_in,
    input wire ac_is_glyph,
    // host memory access
    input wire host_text_we,
    input wire host_glyph_we,
    input wire [6:0] host_addr,
    input wire [7:0] host_wdata,
    output reg [7:0] host_text_rdata_q,
    output reg [7:0] host_glyph_rdata_q,
    // fixed glyph rom port
    output reg [7:0] rom_code_q,
    output reg [3:0] rom_row_q,
    input wire [4:0] rom_dots,
    // status
    output reg busy_flag_q,
    output reg [6:0] ac_q,
    output reg display_on_q,
    output reg cursor_on_q,
    output reg blink_on_q,
    // panel drive
    output reg [`LCD_ROWS-1:0] row_active_q,
    output reg [`LCD_COLS-1:0] column_segment_output_q,
    // expansion driver
    output reg exp_data_q,
    output reg exp_shift_q,
    output reg exp_latch_q
);
    // ****************************************
    // state
    // ****************************************
    localparam ST_INIT = 2'b00;
    localparam ST_RUN = 2'b01;
    reg [1:0] st_q;
    reg [23:0] init_cnt_q;
    reg [6:0] clr_addr_q;
    // last init count, cut to the counter width on purpose
    localparam [31:0] INIT_END = INIT_CYCLES - 1;

    // ****************************************
    // text memory
    // ****************************************
    // whole 7-bit address space kept, so line-two codes from 40h need no folding
    localparam TEXT_WORDS = 128;
    reg [7:0] text_mem [0:TEXT_WORDS-1];

    // refresh position
    reg [8:0] col_q;
    reg [3:0] row_q;
    reg [5:0] frame_q;
    reg [7:0] code_q;
    reg [2:0] fetch_q;
    reg [4:0] dots_q;
    reg cur_here_q;
    reg [2:0] dot_q;
    reg [6:0] char_q;

    wire [3:0] font_rows;
    wire [3:0] cursor_row;
    wire [8:0] exp_last;
    wire [3:0] used_rows;
    wire [5:0] glyph_ref_addr;
    wire [7:0] glyph_ref_data;
    wire [7:0] glyph_host_data;
    wire use_glyph;
    wire [6:0] text_ref_addr;
    wire [4:0] pattern;
    wire show_cursor;
    wire [3:0] font_row;

    // ****************************************
    // font geometry
    // ****************************************
    // row index inside one text line, used for cursor and blanking
    assign font_row = font_5x10 ? row_q : {1'b0, row_q[2:0]};
    assign font_rows = font_5x10 ? `LCD_ROWS_5X10 : `LCD_ROWS_5X7;
    assign cursor_row = font_5x10 ? `LCD_CURSOR_ROW_5X10 : `LCD_CURSOR_ROW_5X7;
    assign exp_last = two_line ? `LCD_EXP_LAST_2LINE : `LCD_EXP_LAST_1LINE;
    assign used_rows = two_line ? 4'hf : font_rows;
    assign use_glyph = (code_q[7:4] == 4'h0);
    // 5x10 drops code bits 0 and 3, 5x7 drops bit 3
    assign glyph_ref_addr = font_5x10 ? {code_q[2:1], row_q}
                                      : {code_q[2:0], row_q[2:0]};
    assign text_ref_addr = (two_line && row_q[3]) ? (`LCD_LINE2_BASE + char_q) : char_q;

    lcd_glyph_ram #(
        .AW(6),
        .DW(8)
    ) lcd_glyph_ram_inst (
        .clock(clock),
        .host_we(host_glyph_we & ~busy_flag_q),
        .host_addr(host_addr[5:0]),
        .host_wdata(host_wdata),
        .host_rdata(glyph_host_data),
        .ref_addr(glyph_ref_addr),
        .ref_rdata(glyph_ref_data)
    );

    // dots visible only for rows inside the font, cursor row overlaid
    assign pattern = use_glyph ? glyph_ref_data[4:0] : rom_dots;
    assign show_cursor = cur_here_q && ((cursor_on_q && font_row == cursor_row) ||
        (blink_on_q && frame_q[5]));

    // ****************************************
    // init, control and address counter
    // ****************************************
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st_q <= ST_INIT;
            init_cnt_q <= 24'h00_0000;
            clr_addr_q <= 7'h00;
            busy_flag_q <= 1'b1;
            ac_q <= 7'h00;
            display_on_q <= 1'b0;
            cursor_on_q <= 1'b0;
            blink_on_q <= 1'b0;
        end
        else
        begin
            case (st_q)
                ST_INIT:
                begin
                    busy_flag_q <= 1'b1;
                    ac_q <= 7'h00;
                    display_on_q <= 1'b0;
                    cursor_on_q <= 1'b0;
                    blink_on_q <= 1'b0;
                    if (clr_addr_q != 7'h7f)
                        clr_addr_q <= clr_addr_q + 7'h01;
                    if (init_cnt_q >= INIT_END[23:0] &&
                        clr_addr_q == 7'h7f)
                        st_q <= ST_RUN;
                    else
                        init_cnt_q <= init_cnt_q + 24'h00_0001;
                end
                ST_RUN:
                begin
                    busy_flag_q <= exec_busy;
                    if (ac_load)
                        ac_q <= ac_in;
                    if (ctrl_load)
                    begin
                        display_on_q <= display_on_in;
                        cursor_on_q <= cursor_on_in;
                        blink_on_q <= blink_on_in;
                    end
                end
                default: st_q <= ST_INIT;
            endcase
        end
    end

    // ****************************************
    // text ram: host port and refresh port
    // ****************************************
    always @(posedge clock)
    begin
        if (st_q == ST_INIT)
        begin
            // clear sweeps every address before busy falls
            text_mem[clr_addr_q] <= 8'h20;
        end
        else if (host_text_we && !busy_flag_q)
            text_mem[host_addr] <= host_wdata;
        host_text_rdata_q <= text_mem[host_addr];
        code_q <= text_mem[text_ref_addr];
    end

    always @(posedge clock or posedge rst)
    begin
        if (rst)
            host_glyph_rdata_q <= 8'h00;
        else
            host_glyph_rdata_q <= glyph_host_data;
    end

    // ****************************************
    // refresh sequencer
    // ****************************************
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            col_q <= 9'h000;
            row_q <= 4'h0;
            frame_q <= 6'h00;
            fetch_q <= 3'h0;
            dot_q <= 3'h0;
            char_q <= 7'h00;
            dots_q <= 5'h00;
            cur_here_q <= 1'b0;
            rom_code_q <= 8'h00;
            rom_row_q <= 4'h0;
            row_active_q <= {`LCD_ROWS{1'b0}};
            column_segment_output_q <= {`LCD_COLS{1'b0}};
            exp_data_q <= 1'b0;
            exp_shift_q <= 1'b0;
            exp_latch_q <= 1'b0;
        end
        else
        begin
            exp_latch_q <= 1'b0;
            exp_shift_q <= 1'b0;
            // fetch: text code, then glyph row, then five dots
            fetch_q <= fetch_q + 3'h1;
            if (fetch_q == 3'h1)
            begin
                rom_code_q <= code_q;
                rom_row_q <= row_q;
            end
            if (fetch_q == 3'h2)
            begin
                // rows beyond the font are blank
                dots_q <= (font_row > cursor_row) ?
                    5'h00 : pattern;
                cur_here_q <= ac_is_glyph ? (char_q == 7'h00)
                    : (text_ref_addr == ac_q);
            end
            if (fetch_q >= 3'h3)
            begin
                dot_q <= dot_q + 3'h1;
                if (col_q < `LCD_LOCAL_COLS)
                    column_segment_output_q <= {column_segment_output_q[`LCD_COLS-2:0],
                        display_on_q & (dots_q[3'h4 - dot_q[2:0]] | show_cursor)};
                else
                begin
                    exp_data_q <= display_on_q & (dots_q[3'h4 - dot_q[2:0]] | show_cursor);
                    exp_shift_q <= 1'b1;
                end
                // last column shifts and latches in the same cycle
                if (col_q + 9'h001 >= exp_last)
                begin
                    col_q <= 9'h000;
                    char_q <= 7'h00;
                    dot_q <= 3'h0;
                    fetch_q <= 3'h0;
                    exp_latch_q <= 1'b1;
                    row_active_q <= {`LCD_ROWS{1'b0}};
                    if (row_q <= used_rows && display_on_q)
                        row_active_q[row_q] <= 1'b1;
                    if (row_q >= used_rows)
                    begin
                        row_q <= 4'h0;
                        frame_q <= frame_q + 6'h01;
                    end
                    else
                        row_q <= row_q + 4'h1;
                end
                else
                begin
                    col_q <= col_q + 9'h001;
                    if (dot_q == 3'h4)
                    begin
                        dot_q <= 3'h0;
                        fetch_q <= 3'h0;
                        char_q <= char_q + 7'h01;
                    end
                end
            end
        end
    end
endmodule // lcd_display_core

// [src/lcd_core_map.vh]
`ifndef LCD_CORE_MAP_VH
`define LCD_CORE_MAP_VH
// ****************************************
// display geometry
// ****************************************
`define LCD_ROWS 16
`define LCD_COLS 40
`define LCD_TEXT_DEPTH 80
`define LCD_GLYPH_DEPTH 64
`define LCD_CHARS_PER_LINE 40
`define LCD_LINE2_BASE 7'h40
// ****************************************
// font rows
// ****************************************
`define LCD_ROWS_5X7 4'h7
`define LCD_ROWS_5X10 4'ha
`define LCD_CURSOR_ROW_5X7 4'h7
`define LCD_CURSOR_ROW_5X10 4'ha
// ****************************************
// expansion column counts
// ****************************************
`define LCD_EXP_LAST_1LINE 9'h190
`define LCD_EXP_LAST_2LINE 9'h0c8
`define LCD_LOCAL_COLS 9'h028
// ****************************************
// timing
// ****************************************
`define LCD_CLK_NS 100
`define LCD_INIT_US 15000
`define LCD_INIT_CYCLES ((`LCD_INIT_US * 1000) / `LCD_CLK_NS)
`define LCD_BLINK_FRAMES 6'd32
`endif

// [src/lcd_glyph_ram.v]
`timescale 1ns/1ps
// ****************************************
// user glyph storage, one host port and one refresh read port
// ****************************************
module lcd_glyph_ram #(
    parameter AW = 6,
    parameter DW = 8
) (
    // clock
    input wire clock,
    // host port
    input wire host_we,
    input wire [AW-1:0] host_addr,
    input wire [DW-1:0] host_wdata,
    output reg [DW-1:0] host_rdata,
    // refresh port
    input wire [AW-1:0] ref_addr,
    output reg [DW-1:0] ref_rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge clock)
    begin
        if (host_we)
            mem[host_addr] <= host_wdata;
        host_rdata <= mem[host_addr];
        ref_rdata <= mem[ref_addr];
    end
endmodule // lcd_glyph_ram

// [dv/lcd_core_asserts.sv]
`timescale 1ns/1ps
// ****
// checker
// ****
module lcd_core_asserts #(
    parameter INIT_CYCLES = 200
) (
    // clock and reset
    input wire clock,
    input wire rst,
    // watched signals
    input wire font_5x10,
    input wire two_line,
    input wire exec_busy,
    input wire busy_flag_q,
    input wire [6:0] ac_q,
    input wire display_on_q,
    input wire cursor_on_q,
    input wire blink_on_q,
    input wire [3:0] rom_row_q,
    input wire [15:0] row_active_q,
    input wire exp_latch_q
);
    localparam int LIM = INIT_CYCLES + 8;
    int cnt_q;
    always @(posedge clock or posedge rst)
        if (rst)
            cnt_q <= 0;
        else if (cnt_q <= LIM)
            cnt_q <= cnt_q + 1;
    // two row latches since the last font or line change
    reg [1:0] cfg_q;
    reg [1:0] seen_q;
    wire settled;
    always @(posedge clock or posedge rst)
        if (rst)
        begin
            cfg_q <= 2'b00;
            seen_q <= 2'b00;
        end
        else
        begin
            cfg_q <= {font_5x10, two_line};
            if (cfg_q != {font_5x10, two_line})
                seen_q <= 2'b00;
            else if (exp_latch_q && seen_q != 2'b10)
                seen_q <= seen_q + 2'b01;
        end
    assign settled = seen_q == 2'b10 && cfg_q == {font_5x10, two_line};
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    chk_busy_init: assert property (cnt_q < INIT_CYCLES - 1 |-> busy_flag_q)
        else $error("busy low during init");
    chk_init_clear: assert property ($fell(busy_flag_q) && cnt_q < LIM
        |-> ac_q == 7'h00 && !display_on_q && !cursor_on_q && !blink_on_q)
        else $error("state not cleared by init");
    chk_busy_follow: assert property (cnt_q > LIM |-> busy_flag_q == $past(exec_busy))
        else $error("busy does not follow execution");
    chk_rows_short: assert property (settled && !two_line && !font_5x10
        |-> row_active_q[15:8] == 8'h00)
        else $error("unused row driven in short font");
    chk_rows_tall: assert property (settled && !two_line && font_5x10
        |-> row_active_q[15:11] == 5'h00)
        else $error("unused row driven in tall font");
    chk_row_single: assert property ($onehot0(row_active_q))
        else $error("more than one row active");
    chk_latch_pulse: assert property (exp_latch_q |=> !exp_latch_q)
        else $error("latch pulse too long");
    chk_tall_rows: assert property (settled && font_5x10 && !two_line
        |-> rom_row_q <= 4'ha)
        else $error("hidden glyph row fetched");
endmodule // lcd_core_asserts
bind lcd_display_core lcd_core_asserts #(.INIT_CYCLES(INIT_CYCLES)) lcd_core_asserts_inst (
    .clock(clock), .rst(rst), .font_5x10(font_5x10), .two_line(two_line),
    .exec_busy(exec_busy), .busy_flag_q(busy_flag_q), .ac_q(ac_q),
    .display_on_q(display_on_q), .cursor_on_q(cursor_on_q), .blink_on_q(blink_on_q),
    .rom_row_q(rom_row_q), .row_active_q(row_active_q), .exp_latch_q(exp_latch_q));

// [dv/lcd_panel_model.sv]
`timescale 1ns/1ps
// ****
// rom and expander model
// ****
module lcd_panel_model (
    // clock and reset
    input wire clock,
    input wire rst,
    // rom port
    input wire [7:0] rom_code_q,
    input wire [3:0] rom_row_q,
    output wire [4:0] rom_dots,
    // expander
    input wire exp_shift_q,
    input wire exp_latch_q,
    output reg [9:0] last_cnt_q,
    output reg [15:0] latch_cnt_q
);
    reg [9:0] cnt_q;
    assign rom_dots = rom_code_q[4:0] ^ {rom_row_q, 1'b0};
    // columns shifted per row
    always @(posedge clock or posedge rst)
        if (rst)
        begin
            cnt_q <= 10'h000;
            last_cnt_q <= 10'h000;
            latch_cnt_q <= 16'h0000;
        end
        else if (exp_latch_q)
        begin
            last_cnt_q <= cnt_q + exp_shift_q;
            cnt_q <= 10'h000;
            latch_cnt_q <= latch_cnt_q + 16'h0001;
        end
        else if (exp_shift_q)
            cnt_q <= cnt_q + 10'h001;
endmodule // lcd_panel_model

// [dv/lcd_display_core_test.sv]
`timescale 1ns/1ps
// ****
// testbench
// ****
module lcd_display_core_test;
    reg clock = 0, rst = 1, font_5x10 = 0, two_line = 0, ctrl_load = 0, exec_busy = 0;
    reg display_on_in = 0, cursor_on_in = 0, blink_on_in = 0, ac_load = 0, ac_is_glyph = 0;
    reg host_text_we = 0, host_glyph_we = 0;
    reg [6:0] ac_in = 0, host_addr = 0;
    reg [7:0] host_wdata = 0, txt [0:127], gly [0:63];
    wire [7:0] trd, grd, rom_code;
    wire [3:0] rom_row;
    wire [4:0] rom_dots;
    wire busy, don, con, bon, exd, exs, exl;
    wire [6:0] ac;
    wire [15:0] rows, latches;
    wire [39:0] cols;
    wire [9:0] last_cnt;
    integer error_cnt = 0, num_checks = 0, i, j, a;
    lcd_display_core #(.INIT_CYCLES(200)) lcd_display_core_inst (
        .clock(clock), .rst(rst), .font_5x10(font_5x10), .two_line(two_line),
        .ctrl_load(ctrl_load), .display_on_in(display_on_in), .cursor_on_in(cursor_on_in),
        .blink_on_in(blink_on_in), .exec_busy(exec_busy), .ac_load(ac_load), .ac_in(ac_in),
        .ac_is_glyph(ac_is_glyph), .host_text_we(host_text_we), .host_glyph_we(host_glyph_we),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_text_rdata_q(trd),
        .host_glyph_rdata_q(grd), .rom_code_q(rom_code), .rom_row_q(rom_row),
        .rom_dots(rom_dots), .busy_flag_q(busy), .ac_q(ac), .display_on_q(don),
        .cursor_on_q(con), .blink_on_q(bon), .row_active_q(rows),
        .column_segment_output_q(cols), .exp_data_q(exd), .exp_shift_q(exs), .exp_latch_q(exl));
    lcd_panel_model lcd_panel_model_inst (
        .clock(clock), .rst(rst), .rom_code_q(rom_code), .rom_row_q(rom_row),
        .rom_dots(rom_dots), .exp_shift_q(exs), .exp_latch_q(exl),
        .last_cnt_q(last_cnt), .latch_cnt_q(latches));
    initial
        forever #50 clock = !clock;
    function [9:0] exp_cols(input tl);
        exp_cols = tl ? 10'h0a0 : 10'h168;
    endfunction
    // local columns of one 5x7 row: chars 0..7, bit 4 first, cursor on row 7
    function [39:0] exp_row(input [3:0] r, input [6:0] cur);
        integer c;
        reg [7:0] cd;
        reg [4:0] d;
        begin
            exp_row = 40'h0;
            for (c = 0; c < 8; c = c + 1)
            begin
                cd = txt[c];
                d = (cd[7:4] == 4'h0) ? gly[{cd[2:0], r[2:0]}][4:0] : cd[4:0] ^ {r, 1'b0};
                if (r == 4'h7 && c == cur)
                    d = 5'h1f;
                exp_row = {exp_row[34:0], d};
            end
        end
    endfunction
    task conclude;
        begin
            if (error_cnt == 0 && num_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input [39:0] got, input [39:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp)
            begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task hold(input lat, input [15:0] n);
        begin
            i = 0;
            while ((lat ? latches < n : busy !== 1'b0) && i < 5000)
            begin
                @(negedge clock);
                i = i + 1;
            end
            if (i == 5000)
            begin
                error_cnt = error_cnt + 1;
                conclude;
            end
        end
    endtask
    task wr(input g, input [6:0] ad, input [7:0] d, input ok);
        begin
            @(negedge clock);
            host_text_we = !g;
            host_glyph_we = g;
            host_addr = ad;
            host_wdata = d;
            if (ok && g)
                gly[ad[5:0]] = d;
            if (ok && !g)
                txt[ad] = d;
            @(negedge clock);
            host_text_we = 0;
            host_glyph_we = 0;
        end
    endtask
    task rd(input g, input [6:0] ad, input [7:0] e);
        begin
            @(negedge clock);
            host_addr = ad;
            repeat (g ? 2 : 1) @(posedge clock);
            @(negedge clock);
            chk(g ? grd : trd, e);
        end
    endtask
    initial
    begin
        a = $urandom(34771);
        repeat (4) @(posedge clock);
        @(negedge clock);
        rst = 0;
        for (j = 0; j < 128; j = j + 1)
            txt[j] = 8'h20;
        hold(0, 0);
        chk(ac, 10'h000);
        chk({don, con, bon}, 10'h000);
        // host repeats the init loads
        ctrl_load = 1;
        ac_load = 1;
        @(negedge clock);
        ctrl_load = 0;
        ac_load = 0;
        for (j = 0; j < 64; j = j + 1)
            wr(1, 7'(j), 8'($urandom), 1);
        for (j = 0; j < 64; j = j + 1)
            rd(1, 7'(j), gly[j]);
        for (j = 0; j < 30; j = j + 1)
            wr(0, 7'($urandom % 40 + ($urandom % 2) * 64), 8'($urandom), 1);
        @(negedge clock);
        exec_busy = 1;
        @(negedge clock);
        for (j = 0; j < 8; j = j + 1)
            wr(j % 2, 7'($urandom % 40), 8'($urandom), 0);
        exec_busy = 0;
        hold(0, 0);
        for (j = 0; j < 128; j = j + 1)
            if (j % 64 < 40)
                rd(0, 7'(j), txt[j]);
        for (j = 0; j < 64; j = j + 1)
            rd(1, 7'(j), gly[j]);
        for (j = 0; j < 3; j = j + 1)
        begin
            @(negedge clock);
            font_5x10 = j[0];
            two_line = j[1];
            {display_on_in, cursor_on_in, blink_on_in} = 3'($urandom);
            ac_in = 7'($urandom % 40);
            ac_is_glyph = j[0];
            ctrl_load = 1;
            ac_load = 1;
            @(negedge clock);
            ctrl_load = 0;
            ac_load = 0;
            hold(1, latches + 16'h0002);
            chk(last_cnt, exp_cols(two_line));
        end
        // local column image of one-line 5x7 rows with the cursor in view
        @(negedge clock);
        font_5x10 = 0;
        two_line = 0;
        ac_is_glyph = 0;
        {display_on_in, cursor_on_in, blink_on_in} = 3'b110;
        ac_in = 7'($urandom % 8);
        ctrl_load = 1;
        ac_load = 1;
        @(negedge clock);
        ctrl_load = 0;
        ac_load = 0;
        hold(1, latches + 16'h0002);
        a = 8;
        for (j = 0; j < 8; j = j + 1)
        begin
            hold(1, latches + 16'h0001);
            for (i = 0; i < 16; i = i + 1)
                if (rows[i] && a == 8)
                    a = i;
            chk(rows, 40'h1 << a);
            chk(cols, exp_row(a[3:0], ac_in));
            a = (a + 1) % 8;
        end
        conclude;
    end
endmodule // lcd_display_core_test
